// File: hdl/uart_msfc_pkg.sv
`default_nettype none
package uart_msfc_pkg;
	// ----------------------------------------------------------------
	// Register offsets on the 4-bit register port
	// ----------------------------------------------------------------
	localparam logic [3:0] OFF_MODEM_OUT = 4'h0;
	localparam logic [3:0] OFF_MODEM_LINE = 4'h1;
	localparam logic [3:0] OFF_SCRATCH = 4'h2;
	localparam logic [3:0] OFF_ENH_FEAT = 4'h3;
	localparam logic [3:0] OFF_INT_SRC = 4'h4;
	localparam logic [3:0] OFF_ON_CHAR1 = 4'h5;
	localparam logic [3:0] OFF_ON_CHAR2 = 4'h6;
	localparam logic [3:0] OFF_STOP_CHAR1 = 4'h7;
	localparam logic [3:0] OFF_STOP_CHAR2 = 4'h8;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MOC_DTR = 0;
	localparam int MOC_RTS = 1;
	localparam int MOC_OUT1 = 2;
	localparam int MOC_OUT2 = 3;
	localparam int MOC_LOOP = 4;
	localparam int EFC_AUTO_CTS = 7;
	localparam int EFC_AUTO_RTS = 6;
	localparam int EFC_SPECIAL = 5;
	localparam int ISS_SPECIAL = 4;
	localparam int ISS_NONE = 0;
	// Status bit order inside the 4-bit line view: cd, ri, dsr, cts
	localparam int LV_CD = 3;
	localparam int LV_RI = 2;
	localparam int LV_DSR = 1;
	localparam int LV_CTS = 0;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] MOC_RESET = 8'h00;
	localparam logic [7:0] EFC_RESET = 8'h00;
	localparam logic [7:0] SCRATCH_RESET = 8'hff;
	localparam logic [7:0] CHAR_RESET = 8'h00;
	localparam logic [1:0] PRIME_CYCLES = 2'h3;
	localparam logic [1:0] RXCMP_NONE = 2'h0;
	localparam logic [1:0] RXCMP_PAIR2 = 2'h1;
	localparam logic [1:0] RXCMP_PAIR1 = 2'h2;
	localparam logic [1:0] RXCMP_BOTH = 2'h3;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// Handshake inputs, all active low at the pins
	typedef struct packed {
		logic cd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} modem_in_t;

	// Two-character sequence tracking
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_GOT_ON = 2'b01,
		SEQ_GOT_OFF = 2'b10
	} seq_state_t;
endpackage
`default_nettype wire

// File: hdl/uart_modem_status_flow_ctrl.sv
`default_nettype none
module uart_modem_status_flow_ctrl #(
	parameter int LEVEL_W = 6
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire uart_msfc_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire uart_msfc_pkg::modem_in_t modem_in,
	output logic dtr_n,
	output logic rts_n,
	output logic out1_n,
	output logic out2_n,
	output logic modem_irq,
	output logic tx_enable,
	output logic [1:0] tx_flow_sel,
	input wire logic [LEVEL_W-1:0] rx_count,
	input wire logic [LEVEL_W-1:0] trig_level,
	input wire logic [LEVEL_W-1:0] trig_next,
	input wire logic [LEVEL_W-1:0] trig_lower,
	output logic rx_trig_irq,
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	output logic rx_store_valid,
	output logic [7:0] rx_store_data,
	output logic rx_on_hit,
	output logic rx_off_hit,
	output logic special_flag
);
	// ----------------------------------------------------------------
	// Character compare, all eight bits of register against character
	// ----------------------------------------------------------------
	function automatic logic char_eq(input logic [7:0] a,
		input logic [7:0] b);
		char_eq = (a == b);
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] moc_q; // Modem output control
	logic [7:0] efc_q; // Enhanced feature control
	logic [7:0] scratch_q; // Scratch storage
	logic [7:0] on1_q, on2_q, off1_q, off2_q; // Flow characters
	logic [3:0] flags_q; // Change flags cd, ri, dsr, cts
	logic [3:0] sync1_q, sync2_q; // Pin synchroniser stages
	logic [3:0] prev_q; // Line view one cycle back
	logic [1:0] prime_q; // Cycles since reset release
	logic rts_hold_q; // Auto RTS deasserted
	logic special_q; // Special character seen
	uart_msfc_pkg::seq_state_t seq_q, seq_d;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire wr = reg_req.wr;
	wire rd = reg_req.rd;
	wire [3:0] ad = reg_req.addr;
	wire wr_moc = wr && (ad == uart_msfc_pkg::OFF_MODEM_OUT);
	wire wr_efc = wr && (ad == uart_msfc_pkg::OFF_ENH_FEAT);
	wire wr_scr = wr && (ad == uart_msfc_pkg::OFF_SCRATCH);
	wire wr_on1 = wr && (ad == uart_msfc_pkg::OFF_ON_CHAR1);
	wire wr_on2 = wr && (ad == uart_msfc_pkg::OFF_ON_CHAR2);
	wire wr_off1 = wr && (ad == uart_msfc_pkg::OFF_STOP_CHAR1);
	wire wr_off2 = wr && (ad == uart_msfc_pkg::OFF_STOP_CHAR2);
	wire rd_line = rd && (ad == uart_msfc_pkg::OFF_MODEM_LINE);
	wire rd_isrc = rd && (ad == uart_msfc_pkg::OFF_INT_SRC);

	// ----------------------------------------------------------------
	// Line view: pins or looped-back control bits
	// ----------------------------------------------------------------
	wire loop = moc_q[uart_msfc_pkg::MOC_LOOP];
	wire [3:0] pin_view = ~sync2_q;
	// Loopback order cd<-out2, ri<-out1, dsr<-dtr, cts<-rts
	wire [3:0] loop_view = {moc_q[uart_msfc_pkg::MOC_OUT2],
		moc_q[uart_msfc_pkg::MOC_OUT1],
		moc_q[uart_msfc_pkg::MOC_DTR],
		moc_q[uart_msfc_pkg::MOC_RTS]};
	wire [3:0] line_view = loop ? loop_view : pin_view;
	wire primed = (prime_q == uart_msfc_pkg::PRIME_CYCLES);
	// Ring flag on pin low-to-high, i.e. status bit falling
	wire [3:0] chg = primed ? {line_view[3] ^ prev_q[3],
		prev_q[2] & ~line_view[2],
		line_view[1:0] ^ prev_q[1:0]} : 4'h0;
	wire [7:0] line_word = {line_view, flags_q};

	// ----------------------------------------------------------------
	// Input synchroniser and priming
	// ----------------------------------------------------------------
	// Stage one feeds only stage two; prime blocks reset-time flags
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= 4'hf;
			sync2_q <= 4'hf;
			prev_q <= 4'h0;
			prime_q <= 2'h0;
		end else begin
			sync1_q <= modem_in;
			sync2_q <= sync1_q;
			prev_q <= line_view;
			if (!primed) begin
				prime_q <= prime_q + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Change flags: set wins over read clear
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flags_q <= 4'h0;
		end else begin
			flags_q <= (flags_q & {4{~rd_line}}) | chg;
		end
	end

	assign modem_irq = |flags_q;

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			moc_q <= uart_msfc_pkg::MOC_RESET;
			efc_q <= uart_msfc_pkg::EFC_RESET;
			scratch_q <= uart_msfc_pkg::SCRATCH_RESET;
			on1_q <= uart_msfc_pkg::CHAR_RESET;
			on2_q <= uart_msfc_pkg::CHAR_RESET;
			off1_q <= uart_msfc_pkg::CHAR_RESET;
			off2_q <= uart_msfc_pkg::CHAR_RESET;
		end else begin
			if (wr_moc) begin
				moc_q <= reg_req.wdata;
			end
			if (wr_efc) begin
				efc_q <= reg_req.wdata;
			end
			if (wr_scr) begin
				scratch_q <= reg_req.wdata;
			end
			if (wr_on1) begin
				on1_q <= reg_req.wdata;
			end
			if (wr_on2) begin
				on2_q <= reg_req.wdata;
			end
			if (wr_off1) begin
				off1_q <= reg_req.wdata;
			end
			if (wr_off2) begin
				off2_q <= reg_req.wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read mux, data one cycle after the strobe
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;
	wire [7:0] isrc_word = {3'h0, special_q, 3'h0,
		~(special_q | modem_irq)};
	always_comb begin
		case (ad)
			uart_msfc_pkg::OFF_MODEM_OUT: rd_mux = moc_q;
			uart_msfc_pkg::OFF_MODEM_LINE: rd_mux = line_word;
			uart_msfc_pkg::OFF_SCRATCH: rd_mux = scratch_q;
			uart_msfc_pkg::OFF_ENH_FEAT: rd_mux = efc_q;
			uart_msfc_pkg::OFF_INT_SRC: rd_mux = isrc_word;
			uart_msfc_pkg::OFF_ON_CHAR1: rd_mux = on1_q;
			uart_msfc_pkg::OFF_ON_CHAR2: rd_mux = on2_q;
			uart_msfc_pkg::OFF_STOP_CHAR1: rd_mux = off1_q;
			uart_msfc_pkg::OFF_STOP_CHAR2: rd_mux = off2_q;
			default: rd_mux = 8'h00; // Unmapped reads zero
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Hardware flow control
	// ----------------------------------------------------------------
	wire auto_cts = efc_q[uart_msfc_pkg::EFC_AUTO_CTS];
	wire auto_rts = efc_q[uart_msfc_pkg::EFC_AUTO_RTS];
	// Halt while CTS pin high, i.e. status bit low
	assign tx_enable = !auto_cts || line_view[uart_msfc_pkg::LV_CTS];
	assign rx_trig_irq = auto_rts && (rx_count >= trig_level);

	// Hysteresis between next trigger and next lower level
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rts_hold_q <= 1'b0;
		end else if (!auto_rts) begin
			rts_hold_q <= 1'b0;
		end else if (rx_count >= trig_next) begin
			rts_hold_q <= 1'b1;
		end else if (rx_count < trig_lower) begin
			rts_hold_q <= 1'b0;
		end
	end

	// Pins idle high in loopback so the far end sees nothing
	assign dtr_n = loop || !moc_q[uart_msfc_pkg::MOC_DTR];
	assign rts_n = loop || rts_hold_q
		|| !moc_q[uart_msfc_pkg::MOC_RTS];
	assign out1_n = loop || !moc_q[uart_msfc_pkg::MOC_OUT1];
	assign out2_n = loop || !moc_q[uart_msfc_pkg::MOC_OUT2];
	assign tx_flow_sel = efc_q[3:2];

	// ----------------------------------------------------------------
	// Receive compare: single pairs, dual sequence, special detect
	// ----------------------------------------------------------------
	wire [1:0] rx_sel = efc_q[1:0];
	wire special_en = efc_q[uart_msfc_pkg::EFC_SPECIAL];
	// Special detect assumes software has zeroed the selection field
	wire special_hit = special_en && rx_valid
		&& char_eq(rx_char, off2_q);
	logic on_hit_d, off_hit_d;

	// Pair selection and two-character sequence
	always_comb begin
		on_hit_d = 1'b0;
		off_hit_d = 1'b0;
		seq_d = seq_q;
		case (rx_sel)
			uart_msfc_pkg::RXCMP_PAIR1: begin
				on_hit_d = rx_valid && char_eq(rx_char, on1_q);
				off_hit_d = rx_valid && char_eq(rx_char, off1_q);
				seq_d = uart_msfc_pkg::SEQ_IDLE;
			end
			uart_msfc_pkg::RXCMP_PAIR2: begin
				on_hit_d = rx_valid && char_eq(rx_char, on2_q);
				off_hit_d = rx_valid && char_eq(rx_char, off2_q);
				seq_d = uart_msfc_pkg::SEQ_IDLE;
			end
			uart_msfc_pkg::RXCMP_BOTH: begin
				if (rx_valid) begin
					// Second char completes; else restart on first
					on_hit_d = (seq_q == uart_msfc_pkg::SEQ_GOT_ON)
						&& char_eq(rx_char, on2_q);
					off_hit_d = (seq_q == uart_msfc_pkg::SEQ_GOT_OFF)
						&& char_eq(rx_char, off2_q);
					if (char_eq(rx_char, on1_q)) begin
						seq_d = uart_msfc_pkg::SEQ_GOT_ON;
					end else if (char_eq(rx_char, off1_q)) begin
						seq_d = uart_msfc_pkg::SEQ_GOT_OFF;
					end else begin
						seq_d = uart_msfc_pkg::SEQ_IDLE;
					end
				end
			end
			default: begin
				seq_d = uart_msfc_pkg::SEQ_IDLE;
			end
		endcase
	end

	// Pass-through store plus compare results, one cycle late
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			seq_q <= uart_msfc_pkg::SEQ_IDLE;
			rx_store_valid <= 1'b0;
			rx_store_data <= 8'h00;
			rx_on_hit <= 1'b0;
			rx_off_hit <= 1'b0;
			special_q <= 1'b0;
		end else begin
			seq_q <= seq_d;
			rx_store_valid <= rx_valid;
			if (rx_valid) begin
				rx_store_data <= rx_char;
			end
			rx_on_hit <= on_hit_d;
			rx_off_hit <= off_hit_d;
			// Hit wins over the clearing read
			special_q <= (special_q && !rd_isrc) || special_hit;
		end
	end

	assign special_flag = special_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_scr_write;
		wr_scr ##1 (rd && ad == uart_msfc_pkg::OFF_SCRATCH);
	endsequence

	// Receiver set to compare both pairs as one sequence
	wire dual_sel = (rx_sel == uart_msfc_pkg::RXCMP_BOTH);

	// First on character, one idle cycle, then the second one
	sequence s_dual_on;
		(rx_valid && dual_sel && rx_char == on1_q)
		##1 (!rx_valid && dual_sel)
		##1 (rx_valid && dual_sel && rx_char == on2_q);
	endsequence

	sequence s_line_read_loop;
		rd_line && loop;
	endsequence

	AST_CTS_CHANGE: assert property (
		(primed && line_view[0] != prev_q[0]) |=> flags_q[0])
		else $error("cts change flag not set");
	AST_CD_CHANGE: assert property (
		(primed && line_view[3] != prev_q[3]) |=> flags_q[3])
		else $error("carrier change flag not set");
	AST_RI_FALL_IGNORED: assert property (
		(primed && line_view[2] && !prev_q[2] && !flags_q[2])
		|=> !flags_q[2])
		else $error("ring flag set on wrong edge");
	AST_RI_RISE: assert property (
		(primed && prev_q[2] && !line_view[2]) |=> flags_q[2])
		else $error("ring flag not set on pin rise");
	AST_READ_CLEARS: assert property (
		(rd_line && chg == 4'h0) |=> (flags_q == 4'h0))
		else $error("line read did not clear flags");
	AST_IRQ_FOLLOWS: assert property (
		$rose(flags_q[1]) |-> modem_irq)
		else $error("modem interrupt missing");
	AST_LOOP_VIEW: assert property (
		s_line_read_loop |=> (reg_rdata[7:4] == $past(loop_view)))
		else $error("loopback line view wrong");
	AST_SCRATCH: assert property (
		s_scr_write |=> (reg_rdata == $past(reg_req.wdata, 2)))
		else $error("scratch readback mismatch");
	AST_CTS_HALT: assert property (
		(auto_cts && sync2_q[0] && !loop) |-> !tx_enable)
		else $error("transmit not halted");
	AST_RTS_DROP: assert property (
		(auto_rts && rts_hold_q && rx_count < trig_lower
		&& rx_count < trig_next) |=> !rts_hold_q)
		else $error("auto rts did not release");
	AST_RTS_MANUAL: assert property (
		!auto_rts |=> (rts_n == (loop || !moc_q[1])))
		else $error("rts not following control bit");
	AST_SPECIAL: assert property (
		special_hit |=> (special_q && rx_store_valid))
		else $error("special character not flagged");
	AST_DUAL_ON: assert property (
		s_dual_on |=> rx_on_hit)
		else $error("dual on pattern not reported");
endmodule
`default_nettype wire

// File: test/modem_peer.sv
`default_nettype none
// Modem side: drives the active-low handshake pins
module modem_peer (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic [3:0] want,
	output var uart_msfc_pkg::modem_in_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------
	// Pin update
	// ------------------------------------------------
	logic [3:0] lag_q; // Cycles spent on a pending change
	initial begin
		pins = 4'hf;
		lag_q = 4'h0;
	end
	// Slow mode lags each change, like a sluggish modem
	always @(posedge core_clk) begin
		if (want === pins) begin
			lag_q <= 4'h0;
		end else if (!slow || lag_q == 4'h7) begin
			pins <= want;
			lag_q <= 4'h0;
		end else begin
			lag_q <= lag_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// File: test/uart_modem_status_flow_ctrl_bench.sv
`default_nettype none
module uart_modem_status_flow_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic core_clk = 1'b0; // 100 MHz
	logic nrst = 1'b0; // Held low at start
	uart_msfc_pkg::reg_req_t req = '0; // Register port request
	uart_msfc_pkg::modem_in_t pins; // From the peer
	logic [3:0] want = 4'h7; // Pin levels: cd_n ri_n dsr_n cts_n
	logic slow = 1'b0; // Peer pace
	logic [7:0] rdata, v, sc_char = 8'h00;
	logic dtr_n, rts_n, out1_n, out2_n, irq, tx_en, trig_irq;
	logic [1:0] flow_sel;
	logic [5:0] cnt = 6'h00, lvl = 6'h08, nxt = 6'h0c, low = 6'h04;
	logic sc_valid = 1'b0, st_valid, on_hit, off_hit, sp_flag;
	logic [7:0] st_data;
	int n_fail = 0;
	int samples_checked = 0;
	logic [3:0] pin_tab [5] = '{4'h6, 4'hc, 4'h8, 4'hc, 4'h7};
	logic [7:0] exp_tab [5] = '{8'h91, 8'h3a, 8'h70, 8'h34, 8'h8b};

	always #5 core_clk = ~core_clk;

	modem_peer peer (.core_clk(core_clk), .slow(slow), .want(want),
		.pins(pins));

	uart_modem_status_flow_ctrl dut (.core_clk(core_clk), .nrst(nrst),
		.reg_req(req), .reg_rdata(rdata), .modem_in(pins),
		.dtr_n(dtr_n), .rts_n(rts_n), .out1_n(out1_n), .out2_n(out2_n),
		.modem_irq(irq), .tx_enable(tx_en), .tx_flow_sel(flow_sel),
		.rx_count(cnt), .trig_level(lvl), .trig_next(nxt),
		.trig_lower(low), .rx_trig_irq(trig_irq), .rx_valid(sc_valid),
		.rx_char(sc_char), .rx_store_valid(st_valid),
		.rx_store_data(st_data), .rx_on_hit(on_hit),
		.rx_off_hit(off_hit), .special_flag(sp_flag));

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask
	// Data sampled in the cycle after the strobe; it holds until the next read
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Let the pin sync and flag stages land
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// One received character, outputs seen a cycle later
	task automatic send(input logic [7:0] c);
		@(posedge core_clk);
		sc_valid <= 1'b1;
		sc_char <= c;
		@(posedge core_clk);
		sc_valid <= 1'b0;
		#1;
	endtask
	// Verdict, reached from the main flow or the watchdog
	task automatic conclude();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard: a stuck run counts as a failure
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		conclude();
	end

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		settle(4);
		rd(4'h1, v); chk(v, 8'h80);
		chk(irq, 1'b0);
		rd(uart_msfc_pkg::OFF_SCRATCH, v); chk(v, 8'hff);
		rd(uart_msfc_pkg::OFF_ENH_FEAT, v); chk(v, 8'h00);
		rd(4'hf, v); chk(v, 8'h00);
		wr(4'h2, 8'ha5); rd(4'h2, v); chk(v, 8'ha5);
		wr(4'h2, 8'h5a); rd(4'h2, v); chk(v, 8'h5a);
		// Write then read with no idle cycle between the strobes
		@(posedge core_clk);
		req.addr <= 4'h2;
		req.wdata <= 8'h3c;
		req.wr <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
		req.rd <= 1'b1;
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1 chk(rdata, 8'h3c);
		// Pin changes both ways; last one through a slow peer
		for (int i = 0; i < 5; i++) begin
			slow <= (i == 4);
			want <= pin_tab[i];
			settle(i == 4 ? 14 : 5);
			chk(irq, exp_tab[i][3:0] != 4'h0);
			rd(4'h1, v); chk(v, exp_tab[i]);
			rd(4'h1, v); chk(v, {exp_tab[i][7:4], 4'h0});
			chk(irq, 1'b0);
		end
		// Back to a prompt peer so later pin steps land in time
		slow <= 1'b0;
		// Loopback: status follows control bits
		wr(4'h0, 8'h10); settle(5); rd(4'h1, v);
		wr(4'h0, 8'h13); settle(5);
		rd(4'h1, v); chk(v, 8'h33);
		chk({dtr_n, rts_n, out1_n, out2_n}, 4'hf);
		wr(4'h0, 8'h1b); settle(5);
		rd(4'h1, v); chk(v, 8'hb8);
		wr(4'h0, 8'h03); settle(5); rd(4'h1, v);
		chk({dtr_n, rts_n, out1_n, out2_n}, 4'h3);
		// Automatic CTS gating
		chk(tx_en, 1'b1);
		wr(4'h3, 8'h80); settle(2); chk(tx_en, 1'b0);
		want <= 4'h6; settle(5); chk(tx_en, 1'b1);
		want <= 4'h7; settle(5); chk(tx_en, 1'b0);
		wr(4'h3, 8'h00); settle(2); chk(tx_en, 1'b1);
		// Automatic RTS against receive fill
		wr(4'h3, 8'h40);
		cnt <= 6'h08; settle(2); chk({trig_irq, rts_n}, 2'h2);
		cnt <= 6'h0c; settle(2); chk(rts_n, 1'b1);
		cnt <= 6'h05; settle(2); chk(rts_n, 1'b1);
		cnt <= 6'h03; settle(2); chk(rts_n, 1'b0);
		cnt <= 6'h0c; wr(4'h3, 8'h00); settle(2);
		chk({trig_irq, rts_n}, 2'h0);
		// Special character, bit 0 against the LSB
		wr(uart_msfc_pkg::OFF_STOP_CHAR2, 8'h81);
		send(8'h81); chk(sp_flag, 1'b0);
		wr(4'h3, 8'h20);
		send(8'h80); chk({st_valid, sp_flag}, 2'h2);
		send(8'h81); chk(st_data, 8'h81);
		chk({st_valid, sp_flag}, 2'h3);
		rd(4'h4, v); chk(v[4], 1'b1);
		chk(sp_flag, 1'b0);
		// Dual and single pair comparison
		wr(4'h5, 8'h11); wr(4'h6, 8'h22);
		wr(4'h7, 8'h33); wr(4'h8, 8'h44);
		wr(4'h3, 8'h03);
		send(8'h11); chk(on_hit, 1'b0);
		send(8'h22); chk(on_hit, 1'b1);
		send(8'h33); send(8'h44); chk(off_hit, 1'b1);
		wr(4'h3, 8'h02); send(8'h33); chk(off_hit, 1'b1);
		wr(4'h3, 8'h01); send(8'h44); chk(off_hit, 1'b1);
		wr(4'h3, 8'h00); send(8'h44); chk(off_hit, 1'b0);
		// Transmit selection field
		for (int i = 0; i < 4; i++) begin
			wr(4'h3, {4'h0, i[1:0], 2'h0}); settle(1);
			chk(flow_sel, i[1:0]);
		end
		conclude();
	end
endmodule
`default_nettype wire
